// ### design/psscl_defs.vh
// register map, field layout and scaling limits of the stroke scaler
`ifndef PSSCL_DEFS_VH
`define PSSCL_DEFS_VH

`define PSSCL_A_CTRL      4'h0
`define PSSCL_A_FACTOR    4'h1
`define PSSCL_A_BATCH     4'h2
`define PSSCL_A_RATES     4'h3
`define PSSCL_A_CAL       4'h4
`define PSSCL_A_FLOW      4'h5
`define PSSCL_A_STATUS    4'h6
`define PSSCL_A_PENDING   4'h7
`define PSSCL_A_TOTAL     4'h8
`define PSSCL_A_KEYS      4'h9
`define PSSCL_A_ID        4'hA

`define PSSCL_MODE_MANUAL 2'h0
`define PSSCL_MODE_ANALOG 2'h1
`define PSSCL_MODE_PULSE  2'h2
`define PSSCL_MODE_BATCH  2'h3

`define PSSCL_ONE         14'h0064
`define PSSCL_FAC_MIN     14'h0001
`define PSSCL_FAC_MAX     14'h270F
`define PSSCL_MEM_MAX     17'h0_FFFF
`define PSSCL_CAL_WIN     8'h0A
`define PSSCL_ID_VALUE    32'h0000_5A01

`define PSSCL_K_START     0
`define PSSCL_K_BATCH     1
`define PSSCL_K_CALSTOP   2
`define PSSCL_K_ACK       3
`define PSSCL_K_CALRUN    4
`define PSSCL_K_CALDONE   5
`define PSSCL_K_RUN       6
`define PSSCL_K_STOP      7

`endif

// ### design/psscl_top.v
// pulse-to-stroke scaler with wishbone register access
// Functional notes
// - pulse mode turns external pulses into single strokes or series
// - factor spans 0.01 to 99.99 in hundredths, including exactly one
// - strokes executed equal factor times pulses received over time
// - remainders accumulate; reaching one issues an extra stroke
// - factor 0.75 gives strokes after two, one, one pulses repeating
// - leaving pulse mode resets the factor to one
// - with memory extension pending strokes accumulate up to 65535
// - pending count overflowing memory with extension enters fault
// - batch strokes per trigger is an integer 1 to 65535
// - batch run starts on local key or external pulse
// - batch memory capped at batch size, or 65535 with extension
// - stroke memory clears whenever the mode changes
// - calibration holds while stroke length stays within ten divisions
// - beyond ten divisions: warning lamp, flashing display and marker
// - calibration run strokes at manual rate until stopped by key
// - completing calibration zeroes total strokes
// - after calibration the pump stays stopped
// - auxiliary rate from external input overrides mode rate, shows flag
// - consecutive unconfirmed strokes reaching limit stop the pump
// - feedback limit setting only offered with a monitor detected
// - batch factor sets strokes per external pulse or key trigger
// - brief programming key press clears the fault indication
//
// The implementer's own choices: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/10ps
`include "psscl_defs.vh"

module psscl_top #(
    parameter MEM_W = 16                  // pending counter width
) (
    input  wire        clk_i,             // 25 MHz clock
    input  wire        rst_i,             // synchronous reset, high
    input  wire        ce_i,              // clock enable
    input  wire        wb_cyc_i,          // wishbone cycle
    input  wire        wb_stb_i,          // wishbone strobe
    input  wire        wb_we_i,           // wishbone write
    input  wire [3:0]  wb_adr_i,          // word index
    input  wire [3:0]  wb_sel_i,          // byte selects
    input  wire [31:0] wb_dat_i,          // write data
    output reg  [31:0] wb_dat_o,          // read data
    output reg         wb_ack_o,          // acknowledge
    input  wire        ext_pulse_i,       // external control pulse, level
    input  wire        aux_act_i,         // auxiliary rate request
    input  wire        mon_present_i,     // feedback monitor attached
    input  wire        mon_confirm_i,     // stroke confirmation pulse
    input  wire [7:0]  stroke_len_i,      // stroke length divisions
    output wire        stroke_req_o,      // stroke request to drive
    input  wire        stroke_ack_i,      // drive accepts stroke
    output reg  [15:0] rate_o,            // demanded stroke rate
    output reg         aux_flag_o,        // auxiliary indicator
    output reg         warn_lamp_o,       // yellow warning lamp
    output reg         disp_flash_o,      // flash continuous display
    output reg         calib_flash_o,     // flashing calibration marker
    output reg         fault_o,           // fault state
    output reg         run_o              // pump running
);

    reg  [1:0]       mode_r;
    reg              mem_ext_r;
    reg  [13:0]      factor_r;
    reg  [15:0]      batch_r;
    reg  [15:0]      man_rate_r;
    reg  [15:0]      aux_rate_r;
    reg  [7:0]       cal_len_r;
    reg              cal_valid_r;
    reg  [7:0]       flow_lim_r;
    reg  [7:0]       miss_cnt_r;
    reg  [13:0]      acc_r;
    reg  [MEM_W-1:0] pend_r;
    reg  [31:0]      total_r;
    reg              pulse_d_r;
    reg              cal_run_r;
    reg              flow_stop_r;

    reg  [MEM_W:0]   pend_nxt;
    reg  [14:0]      sum;
    reg  [14:0]      quo;
    reg  [14:0]      rem;
    reg  [7:0]       whole;
    reg  [13:0]      frac;
    reg  [MEM_W:0]   cap;
    reg  [7:0]       dlen;

    wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr      = ce_i & wb_req & wb_we_i;
    wire pulse_e = ext_pulse_i & ~pulse_d_r;
    wire key_wr  = wr & (wb_adr_i == `PSSCL_A_KEYS) & wb_sel_i[0];
    wire k_start = key_wr & wb_dat_i[`PSSCL_K_START];
    wire k_batch = key_wr & wb_dat_i[`PSSCL_K_BATCH];
    wire k_cstop = key_wr & wb_dat_i[`PSSCL_K_CALSTOP];
    wire k_ack   = key_wr & wb_dat_i[`PSSCL_K_ACK];
    wire k_crun  = key_wr & wb_dat_i[`PSSCL_K_CALRUN];
    wire k_cdone = key_wr & wb_dat_i[`PSSCL_K_CALDONE];
    wire k_run   = key_wr & wb_dat_i[`PSSCL_K_RUN];
    wire k_stop  = key_wr & wb_dat_i[`PSSCL_K_STOP];
    wire mode_wr = wr & (wb_adr_i == `PSSCL_A_CTRL) & wb_sel_i[0];
    wire [1:0] mode_new = wb_dat_i[1:0];
    wire mode_chg = mode_wr & (mode_new != mode_r);
    wire take    = stroke_req_o & stroke_ack_i;

    // monitor gone means its limit is not in force
    wire flow_on = mon_present_i & (flow_lim_r != 8'h00);

    assign stroke_req_o = run_o & ~fault_o & ~flow_stop_r
                          & (pend_r != {MEM_W{1'b0}});

    // a factor of 0 would stall pulse mode, so clamp into range
    function [13:0] psscl_clamp;
        input [13:0] v;
        begin
            if (v < `PSSCL_FAC_MIN)
                psscl_clamp = `PSSCL_FAC_MIN;
            else if (v > `PSSCL_FAC_MAX)
                psscl_clamp = `PSSCL_FAC_MAX;
            else
                psscl_clamp = v;
        end
    endfunction

    // strokes due per pulse: integer part of (acc + factor) / one
    always @* begin
        sum   = {1'b0, acc_r} + {1'b0, factor_r};
        quo   = sum / {1'b0, `PSSCL_ONE};
        rem   = sum % {1'b0, `PSSCL_ONE};
        // at most 100 strokes per pulse, so eight bits carry the quotient
        whole = quo[7:0];
        frac  = rem[13:0];
    end

    // memory cap for pending strokes
    always @* begin
        if (mem_ext_r)
            cap = `PSSCL_MEM_MAX;
        else if (mode_r == `PSSCL_MODE_BATCH)
            cap = {1'b0, batch_r};
        else
            cap = `PSSCL_MEM_MAX;
    end

    always @* begin
        pend_nxt = {1'b0, pend_r} - {{MEM_W{1'b0}}, take};
        if (run_o && !fault_o) begin
            if (mode_r == `PSSCL_MODE_PULSE && pulse_e)
                pend_nxt = pend_nxt + {{(MEM_W-7){1'b0}}, whole};
            else if (mode_r == `PSSCL_MODE_BATCH && (pulse_e || k_batch))
                pend_nxt = pend_nxt + {1'b0, batch_r};
        end
    end

    always @* begin
        if (stroke_len_i > cal_len_r)
            dlen = stroke_len_i - cal_len_r;
        else
            dlen = cal_len_r - stroke_len_i;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_r      <= `PSSCL_MODE_MANUAL;
            mem_ext_r   <= 1'b0;
            factor_r    <= `PSSCL_ONE;
            batch_r     <= 16'h0001;
            man_rate_r  <= 16'h0000;
            aux_rate_r  <= 16'h0000;
            cal_len_r   <= 8'h00;
            cal_valid_r <= 1'b0;
            flow_lim_r  <= 8'h00;
            miss_cnt_r  <= 8'h00;
            acc_r       <= 14'h0000;
            pend_r      <= {MEM_W{1'b0}};
            total_r     <= 32'h0000_0000;
            pulse_d_r   <= 1'b0;
            cal_run_r   <= 1'b0;
            flow_stop_r <= 1'b0;
            fault_o     <= 1'b0;
            run_o       <= 1'b0;
        end else if (ce_i) begin
            pulse_d_r <= ext_pulse_i;
            if (wr && wb_adr_i == `PSSCL_A_FACTOR && wb_sel_i[1:0] == 2'b11)
                factor_r <= psscl_clamp(wb_dat_i[13:0]);
            if (wr && wb_adr_i == `PSSCL_A_BATCH && wb_sel_i[1:0] == 2'b11
                && wb_dat_i[15:0] != 16'h0000)
                batch_r <= wb_dat_i[15:0];
            if (wr && wb_adr_i == `PSSCL_A_RATES) begin
                man_rate_r <= wb_dat_i[15:0];
                aux_rate_r <= wb_dat_i[31:16];
            end
            if (wr && wb_adr_i == `PSSCL_A_FLOW && mon_present_i)
                flow_lim_r <= wb_dat_i[7:0];
            if (mode_wr) begin
                mode_r    <= mode_new;
                mem_ext_r <= wb_dat_i[2];
            end
            if (mode_chg) begin
                if (mode_new != `PSSCL_MODE_PULSE)
                    factor_r <= `PSSCL_ONE;
                acc_r  <= 14'h0000;
                pend_r <= {MEM_W{1'b0}};
            end else begin
                if (pend_nxt > cap) begin
                    // batch without extension simply saturates
                    pend_r <= cap[MEM_W-1:0];
                    if (mem_ext_r)
                        fault_o <= 1'b1;
                end else begin
                    pend_r <= pend_nxt[MEM_W-1:0];
                end
                if (mode_r == `PSSCL_MODE_PULSE && pulse_e && run_o
                    && !fault_o)
                    acc_r <= frac;
            end
            if (k_ack && !(mem_ext_r && pend_nxt > cap))
                fault_o <= 1'b0;
            if (take)
                total_r <= total_r + 32'h0000_0001;
            // calibration run strokes at the manual rate until stopped
            if (k_crun) begin
                cal_run_r <= 1'b1;
                run_o     <= 1'b1;
            end
            if (k_cstop)
                cal_run_r <= 1'b0;
            if (k_cdone) begin
                cal_run_r   <= 1'b0;
                cal_len_r   <= stroke_len_i;
                cal_valid_r <= 1'b1;
                total_r     <= 32'h0000_0000;
                run_o       <= 1'b0;
            end else if (k_stop) begin
                run_o <= 1'b0;
            end else if (k_run && !cal_run_r) begin
                run_o <= 1'b1;
            end
            if (k_run || k_ack)
                flow_stop_r <= 1'b0;
            // feedback monitor: count consecutive misses
            if (!flow_on || mon_confirm_i) begin
                miss_cnt_r <= 8'h00;
            end else if (take) begin
                miss_cnt_r <= miss_cnt_r + 8'h01;
                if (miss_cnt_r + 8'h01 >= flow_lim_r) begin
                    // a stop on the limit wins over a restart key
                    flow_stop_r <= 1'b1;
                    run_o       <= 1'b0;
                end
            end
        end
    end

    // indicators and rate selection, registered
    always @(posedge clk_i) begin
        if (rst_i) begin
            rate_o        <= 16'h0000;
            aux_flag_o    <= 1'b0;
            warn_lamp_o   <= 1'b0;
            disp_flash_o  <= 1'b0;
            calib_flash_o <= 1'b0;
        end else if (ce_i) begin
            aux_flag_o <= aux_act_i;
            if (aux_act_i)
                rate_o <= aux_rate_r;
            else if (cal_run_r || mode_r == `PSSCL_MODE_MANUAL)
                rate_o <= man_rate_r;
            else
                rate_o <= man_rate_r;
            warn_lamp_o   <= cal_valid_r & (dlen > `PSSCL_CAL_WIN);
            disp_flash_o  <= cal_valid_r & (dlen > `PSSCL_CAL_WIN);
            calib_flash_o <= cal_valid_r & (dlen > `PSSCL_CAL_WIN);
        end
    end

    // wishbone slave: one wait-free ack cycle per request
    always @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            wb_dat_o <= 32'h0000_0000;
            if (wb_req && !wb_we_i) begin
                case (wb_adr_i)
                    `PSSCL_A_CTRL:    wb_dat_o <= {29'h0, mem_ext_r, mode_r};
                    `PSSCL_A_FACTOR:  wb_dat_o <= {18'h0, factor_r};
                    `PSSCL_A_BATCH:   wb_dat_o <= {16'h0, batch_r};
                    `PSSCL_A_RATES:   wb_dat_o <= {aux_rate_r, man_rate_r};
                    `PSSCL_A_CAL:     wb_dat_o <= {23'h0, cal_valid_r,
                                                   cal_len_r};
                    `PSSCL_A_FLOW:    wb_dat_o <= {16'h0, miss_cnt_r,
                                                   flow_lim_r};
                    `PSSCL_A_STATUS:  wb_dat_o <= {25'h0, mon_present_i,
                                                   flow_stop_r, cal_run_r,
                                                   warn_lamp_o, aux_flag_o,
                                                   fault_o, run_o};
                    `PSSCL_A_PENDING: wb_dat_o <= {{(32-MEM_W){1'b0}},
                                                   pend_r};
                    `PSSCL_A_TOTAL:   wb_dat_o <= total_r;
                    `PSSCL_A_ID:      wb_dat_o <= `PSSCL_ID_VALUE;
                    default:          wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // psscl_top

// ### tb/psscl_props.sv
// concurrent checks on the stroke scaler ports
`timescale 1ns/10ps
module psscl_props (
    input logic clk_i,           // clock
    input logic rst_i,           // sync reset
    input logic ce_i,            // clock enable
    input logic wb_cyc_i,        // bus cycle
    input logic wb_stb_i,        // bus strobe
    input logic wb_we_i,         // bus write
    input logic wb_ack_o,        // bus ack
    input logic aux_act_i,       // aux request
    input logic aux_flag_o,      // aux indicator
    input logic stroke_req_o,    // stroke request
    input logic stroke_ack_i,    // drive accept
    input logic warn_lamp_o,     // warning lamp
    input logic disp_flash_o,    // display flash
    input logic calib_flash_o,   // calib marker
    input logic fault_o,         // fault
    input logic run_o            // running
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_ack_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    AST_ACK_PULSE: assert property (s_take ##1 ce_i |-> s_ack_pulse)
        else $error("ack not a one cycle answer");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    AST_REQ_HOLD: assert property (stroke_req_o && !stroke_ack_i &&
        !fault_o && !(wb_stb_i && wb_we_i) |=> stroke_req_o || fault_o)
        else $error("stroke request dropped before accept");
    AST_FAULT_HOLD: assert property (fault_o &&
        !(wb_stb_i && wb_we_i) |=> fault_o)
        else $error("fault cleared without acknowledge");
    AST_WARN_SET: assert property (warn_lamp_o |->
        disp_flash_o && calib_flash_o) else $error("warning set incomplete");
    AST_AUX_ON: assert property ((aux_act_i && ce_i) ##1 aux_act_i |->
        aux_flag_o)
        else $error("aux indicator missing");
    AST_RUN_RISE: assert property ($rose(run_o) |->
        $past(wb_stb_i && wb_we_i)) else $error("pump started by itself");
    AST_RUN_FALL: assert property ($fell(run_o) |-> fault_o ||
        $past(wb_stb_i && wb_we_i) || $past(stroke_ack_i) ||
        $past(stroke_ack_i, 2)) else $error("pump stopped without cause");
endmodule // psscl_props

bind psscl_top psscl_props u_props (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .aux_act_i(aux_act_i), .aux_flag_o(aux_flag_o),
    .stroke_req_o(stroke_req_o), .stroke_ack_i(stroke_ack_i),
    .warn_lamp_o(warn_lamp_o), .disp_flash_o(disp_flash_o),
    .calib_flash_o(calib_flash_o), .fault_o(fault_o), .run_o(run_o)
);

// ### tb/psscl_pulse_src.sv
// contact meter model: one closure per counted unit
`timescale 1ns/10ps
module psscl_pulse_src (
    input  logic clk_i,         // system clock
    output logic ext_pulse_o    // contact level
);
    initial ext_pulse_o = 1'b0;
    // two cycles closed and two open, so no edge is lost to sampling
    task automatic fire(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk_i);
            ext_pulse_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            ext_pulse_o <= 1'b0;
            @(posedge clk_i);
        end
    endtask
endmodule // psscl_pulse_src

// ### tb/psscl_top_tb.sv
// self-checking bench for the pulse-to-stroke scaler
`timescale 1ns/10ps
`include "psscl_defs.vh"
module psscl_top_tb;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    logic        aux = 1'b0, mon = 1'b0, conf = 1'b1, sack = 1'b1, ce = 1'b1;
    logic        pulse, ack, req, auxf, warn, dflash, cflash, fault, run;
    logic [3:0]  adr = 4'h0, sel = 4'h0;
    logic [7:0]  slen = 8'h28;
    logic [15:0] rate;
    logic [31:0] dat = 32'h0, dat_o, rdat, t0;
    int          err_count = 0, total_checks = 0;

    initial forever #20 clk_i = ~clk_i;
    psscl_top u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .ext_pulse_i(pulse), .aux_act_i(aux), .mon_present_i(mon),
        .mon_confirm_i(conf), .stroke_len_i(slen), .stroke_req_o(req),
        .stroke_ack_i(sack), .rate_o(rate), .aux_flag_o(auxf),
        .warn_lamp_o(warn), .disp_flash_o(dflash),
        .calib_flash_o(cflash), .fault_o(fault), .run_o(run)
    );
    psscl_pulse_src u_src (.clk_i(clk_i), .ext_pulse_o(pulse));

    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= s;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 64);
        rdat = dat_o;
        cyc <= 1'b0;
        if (n >= 64) begin
            err_count++;
            close_out();
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, 4'hF);
        chk(rdat, exp);
    endtask
    task automatic key(input int k);
        wr(`PSSCL_A_KEYS, 32'h1 << k);
    endtask
    // wait until the pending strokes have all been accepted
    task automatic drain();
        int n;
        n = 0;
        repeat (2) @(posedge clk_i);
        while (req !== 1'b0 && n < 300) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 300) begin
            err_count++;
            close_out();
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rdc(`PSSCL_A_FACTOR, 32'h64);
        rdc(4'hF, 32'h0);
        wr(`PSSCL_A_CTRL, 32'h2);
        wr(`PSSCL_A_FACTOR, 32'h2710);
        rdc(`PSSCL_A_FACTOR, 32'h270F);
        wr(`PSSCL_A_FACTOR, 32'h4B);
        key(`PSSCL_K_RUN);
        for (int i = 1; i <= 4; i++) begin
            u_src.fire(1);
            drain();
            rdc(`PSSCL_A_TOTAL, i * 75 / 100);
        end
        wr(`PSSCL_A_FACTOR, 32'hFA);
        u_src.fire(2);
        drain();
        rdc(`PSSCL_A_TOTAL, 32'h8);
        wr(`PSSCL_A_CTRL, 32'h0);
        rdc(`PSSCL_A_FACTOR, 32'h64);
        // a factor write without both low byte lanes must be ignored
        bus(1'b1, `PSSCL_A_FACTOR, 32'h1F4, 4'h1);
        rdc(`PSSCL_A_FACTOR, 32'h64);
        $display("test scaling done");
        // stalled drive: 656 pulses at 99.99 overrun the memory
        sack <= 1'b0;
        wr(`PSSCL_A_CTRL, 32'h6);
        wr(`PSSCL_A_FACTOR, 32'h270F);
        key(`PSSCL_K_RUN);
        u_src.fire(656);
        repeat (4) @(posedge clk_i);
        chk(fault, 1'b1);
        rdc(`PSSCL_A_PENDING, 32'hFFFF);
        key(`PSSCL_K_ACK);
        chk(fault, 1'b0);
        wr(`PSSCL_A_CTRL, 32'h4);
        rdc(`PSSCL_A_PENDING, 32'h0);
        wr(`PSSCL_A_CTRL, 32'h3);
        wr(`PSSCL_A_BATCH, 32'h0);
        rdc(`PSSCL_A_BATCH, 32'h1);
        wr(`PSSCL_A_BATCH, 32'h3);
        key(`PSSCL_K_RUN);
        key(`PSSCL_K_BATCH);
        rdc(`PSSCL_A_PENDING, 32'h3);
        u_src.fire(1);
        rdc(`PSSCL_A_PENDING, 32'h3);
        sack <= 1'b1;
        drain();
        rdc(`PSSCL_A_PENDING, 32'h0);
        bus(1'b0, `PSSCL_A_TOTAL, 32'h0, 4'hF);
        t0 = rdat;
        u_src.fire(1);
        drain();
        rdc(`PSSCL_A_TOTAL, t0 + 32'h3);
        $display("test memory and batch done");
        wr(`PSSCL_A_RATES, 32'h0123_0045);
        aux <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk({auxf, rate}, 32'h1_0123);
        // clock enable low freezes the indicator although the input drops
        ce <= 1'b0;
        aux <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk(auxf, 1'b1);
        ce <= 1'b1;
        key(`PSSCL_K_CALRUN);
        repeat (3) @(posedge clk_i);
        chk(rate, 32'h45);
        key(`PSSCL_K_CALSTOP);
        key(`PSSCL_K_CALDONE);
        chk(run, 1'b0);
        rdc(`PSSCL_A_TOTAL, 32'h0);
        slen <= 8'h32;
        repeat (3) @(posedge clk_i);
        chk(warn, 1'b0);
        slen <= 8'h33;
        repeat (3) @(posedge clk_i);
        chk({dflash, cflash, warn}, 32'h7);
        wr(`PSSCL_A_FLOW, 32'h3);
        rdc(`PSSCL_A_FLOW, 32'h0);
        mon <= 1'b1;
        conf <= 1'b0;
        wr(`PSSCL_A_FLOW, 32'h3);
        wr(`PSSCL_A_CTRL, 32'h2);
        key(`PSSCL_K_RUN);
        u_src.fire(2);
        drain();
        chk(run, 1'b1);
        u_src.fire(1);
        drain();
        chk(run, 1'b0);
        $display("test calibration and flow done");
        close_out();
    end
endmodule // psscl_top_tb
